// *** design/icc_pkg.sv ***
// Package for the interrupt control configuration block.
// Assumes an AHB-Lite slave port with 32-bit data on one clock.
//----------------------------------------------------------------------
// Functional notes
// [R1] Shadow-select bit 16 chooses shadow register set for single vector.
// [R2] Bit 12 set gives multi-vectored mode, clear gives single-vectored.
// [R3] Threshold 010..111 lets priorities at or below it start timer.
// [R4] Threshold 001 lets only group priority 1 start the timer.
// [R5] Threshold 000 keeps the proximity timer disabled entirely.
// [R6] One edge-polarity bit per external input, inputs 0..4 at bits 0..4.
// [R7] Polarity 1 detects rising edges, polarity 0 detects falling edges.
// [R8] Bits 31-17, 15-13, 11 and 7-5 read back as zero.
// [R9] Inputs are synchronised; one request pulse per detected edge.
//----------------------------------------------------------------------
package icc_pkg;

  // Register map
  localparam logic [31:0] ICC_CTRL_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] ICC_STATUS_OFFSET  = 32'h0000_0004;
  localparam logic [31:0] ICC_CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] ICC_CTRL_WMASK     = 32'h0001_171f;

  // Field positions in the control register
  localparam int ICC_SHADOW_BIT    = 16;
  localparam int ICC_MULTI_VEC_BIT = 12;
  localparam int ICC_PROX_LSB      = 8;
  localparam int ICC_PROX_W        = 3;
  localparam int ICC_EP_LSB        = 0;
  localparam int ICC_NUM_EXT       = 5;

  // Proximity threshold encodings
  localparam logic [2:0] ICC_PROX_OFF = 3'h0;
  localparam logic [2:0] ICC_PROX_ONE = 3'h1;

  // AHB-Lite encodings
  localparam logic [1:0] ICC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ICC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] ICC_HSIZE_WORD    = 3'h2;
  localparam logic       ICC_HRESP_OKAY    = 1'b0;

  // Decoded configuration carried to the core side
  typedef struct packed {
    logic                   shadow_sel;
    logic                   multi_vec;
    logic [ICC_PROX_W-1:0]  prox_thresh;
    logic [ICC_NUM_EXT-1:0] edge_pol;
  } icc_cfg_t;

  // Register access captured at the address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } icc_acc_t;

endpackage

// *** design/icc_ext_edge.sv ***
// Edge detector for the external interrupt inputs.
// Assumes asynchronous pins; each passes two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
module icc_ext_edge
  import icc_pkg::*;
#(
  parameter int N = ICC_NUM_EXT
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] polarity,
  output logic [N-1:0]      level,
  output logic [N-1:0]      req_pulse
);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_in;                           // R9
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;

  // Per-input edge choice, registered in one process below
  wire logic [N-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      logic rise;
      logic fall;
      assign rise   = sync_r[g] & ~prev_r[g];
      assign fall   = ~sync_r[g] & prev_r[g];
      assign hit[g] = polarity[g] ? rise : fall;           // R7

      AST_EDGE_ONE: assert property (                      // R9
        @(posedge hclk) disable iff (!hresetn)
        req_pulse[g] |=> !req_pulse[g])
        else $error("request pulse lasted more than one cycle");
      AST_EDGE_POL: assert property (                      // R7
        @(posedge hclk) disable iff (!hresetn)
        (sync_r[g] && !prev_r[g] && polarity[g]) |=> req_pulse[g])
        else $error("rising edge with rising polarity not reported");
      AST_EDGE_FALL: assert property (                     // R7
        @(posedge hclk) disable iff (!hresetn)
        (!sync_r[g] && prev_r[g] && !polarity[g]) |=> req_pulse[g])
        else $error("falling edge with falling polarity not reported");
    end
  endgenerate

  // One request pulse per selected edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_pulse <= '0;
    end else begin
      req_pulse <= hit;                                    // R9
    end
  end

endmodule
`default_nettype wire

// *** design/icc_prox_gate.sv ***
// Proximity timer start qualifier.
// Assumes priority and threshold stable in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
module icc_prox_gate
  import icc_pkg::*;
(
  input  wire logic [ICC_PROX_W-1:0] thresh,
  input  wire logic                  irq_valid,
  input  wire logic [ICC_PROX_W-1:0] irq_prio,
  output logic                       start
);

  // Threshold decode
  function automatic logic prio_starts(input logic [ICC_PROX_W-1:0] th,
                                       input logic [ICC_PROX_W-1:0] pr);
    case (th)
      ICC_PROX_OFF: prio_starts = 1'b0;                 // R5
      ICC_PROX_ONE: prio_starts = (pr == ICC_PROX_ONE); // R4
      default:      prio_starts = (pr <= th);           // R3
    endcase
  endfunction

  assign start = irq_valid & prio_starts(thresh, irq_prio);

endmodule
`default_nettype wire

// *** design/icc_top.sv ***
// Interrupt control configuration: AHB-Lite register slave plus outputs.
// Assumes a single AHB-Lite master; hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module icc_top
  import icc_pkg::*;
#(
  parameter int N = ICC_NUM_EXT
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [N-1:0]          ext_irq_pin,
  output logic [N-1:0]               ext_irq_req,
  input  wire logic                  irq_valid,
  input  wire logic [ICC_PROX_W-1:0] irq_prio,
  output logic                       prox_timer_start,
  output logic                       multi_vector_enable,
  output logic                       single_vector_shadow_select
);

  //--------------------------------------------------------------------
  // Register state
  //--------------------------------------------------------------------
  logic [31:0]  interrupt_control_r;
  icc_acc_t     acc_r;
  logic [N-1:0] pin_level;
  logic [N-1:0] edge_pulse;
  icc_cfg_t     cfg;

  // Decoded fields, one driver for the whole struct
  assign cfg = '{shadow_sel:  interrupt_control_r[ICC_SHADOW_BIT],
                 multi_vec:   interrupt_control_r[ICC_MULTI_VEC_BIT],
                 prox_thresh: interrupt_control_r[ICC_PROX_LSB +: ICC_PROX_W],
                 edge_pol:    interrupt_control_r[ICC_EP_LSB +: N]};  // R6

  //--------------------------------------------------------------------
  // AHB-Lite slave
  //--------------------------------------------------------------------
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = ICC_HRESP_OKAY;

  function automatic logic is_xfer(input logic [1:0] t);
    is_xfer = (t == ICC_HTRANS_NONSEQ) || (t == ICC_HTRANS_SEQ);
  endfunction

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
    end else if (hready) begin
      acc_r.valid <= hsel & is_xfer(htrans);
      acc_r.write <= hwrite;
      acc_r.addr  <= haddr;
    end
  end

  // Control register write, reserved bits held at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_control_r <= ICC_CTRL_RESET;
    end else if (acc_r.valid && acc_r.write &&
                 acc_r.addr == ICC_CTRL_OFFSET) begin
      interrupt_control_r <= hwdata & ICC_CTRL_WMASK;             // R8
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && is_xfer(htrans) && !hwrite) begin
      case (haddr)
        ICC_CTRL_OFFSET:   hrdata <= interrupt_control_r & ICC_CTRL_WMASK;
        ICC_STATUS_OFFSET: hrdata <= {{(32-N){1'b0}}, pin_level};
        default:           hrdata <= '0;
      endcase
    end
  end

  AST_RSVD_ZERO: assert property (                          // R8
    @(posedge hclk) disable iff (!hresetn)
    (interrupt_control_r & ~ICC_CTRL_WMASK) == '0)
    else $error("reserved control bits not zero");
  AST_WRITE_TAKES: assert property (                        // R8
    @(posedge hclk) disable iff (!hresetn)
    (acc_r.valid && acc_r.write && acc_r.addr == ICC_CTRL_OFFSET)
    |=> interrupt_control_r == ($past(hwdata) & ICC_CTRL_WMASK))
    else $error("control write not stored");

  //--------------------------------------------------------------------
  // Configuration outputs
  //--------------------------------------------------------------------
  assign multi_vector_enable         = cfg.multi_vec;                // R2
  assign single_vector_shadow_select = cfg.shadow_sel;               // R1

  // Outputs follow the bit that the last control write carried
  AST_MULTI_VEC: assert property (                          // R2
    @(posedge hclk) disable iff (!hresetn)
    (acc_r.valid && acc_r.write && acc_r.addr == ICC_CTRL_OFFSET)
    |=> multi_vector_enable == $past(hwdata[ICC_MULTI_VEC_BIT]))
    else $error("vector mode output does not follow written bit");
  AST_SHADOW: assert property (                             // R1
    @(posedge hclk) disable iff (!hresetn)
    (acc_r.valid && acc_r.write && acc_r.addr == ICC_CTRL_OFFSET)
    |=> single_vector_shadow_select == $past(hwdata[ICC_SHADOW_BIT]))
    else $error("shadow select output does not follow written bit");

  //--------------------------------------------------------------------
  // External inputs and proximity qualifier
  //--------------------------------------------------------------------
  icc_ext_edge #(
    .N (N)
  ) u_edge (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (ext_irq_pin),
    .polarity  (cfg.edge_pol),
    .level     (pin_level),
    .req_pulse (edge_pulse)
  );

  assign ext_irq_req = edge_pulse;                                    // R9

  icc_prox_gate u_prox (
    .thresh    (cfg.prox_thresh),
    .irq_valid (irq_valid),
    .irq_prio  (irq_prio),
    .start     (prox_timer_start)
  );

  AST_PROX_OFF: assert property (                           // R5
    @(posedge hclk) disable iff (!hresetn)
    (cfg.prox_thresh == ICC_PROX_OFF) |-> !prox_timer_start)
    else $error("proximity timer started while disabled");
  AST_PROX_ONE: assert property (                           // R4
    @(posedge hclk) disable iff (!hresetn)
    (cfg.prox_thresh == ICC_PROX_ONE && irq_valid)
    |-> (prox_timer_start == (irq_prio == ICC_PROX_ONE)))
    else $error("threshold one qualified wrong priority");
  AST_PROX_LE: assert property (                            // R3
    @(posedge hclk) disable iff (!hresetn)
    (cfg.prox_thresh > ICC_PROX_ONE && irq_valid)
    |-> (prox_timer_start == (irq_prio <= cfg.prox_thresh)))
    else $error("threshold compare wrong");
  AST_EP_MAP: assert property (                             // R6
    @(posedge hclk) disable iff (!hresetn)
    (acc_r.valid && acc_r.write && acc_r.addr == ICC_CTRL_OFFSET)
    |=> cfg.edge_pol == $past(hwdata[ICC_EP_LSB +: N]))
    else $error("edge polarity mapping wrong");

endmodule
`default_nettype wire

// *** tb/icc_core_model.sv ***
// Core-side model: drives the external pins, counts request pulses.
// Assumes the bench sets pin levels; pins move out of phase with hclk.
`timescale 1ns/1ps
`default_nettype none
module icc_core_model
  import icc_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic [ICC_NUM_EXT-1:0] pin_target,
  input  wire logic [ICC_NUM_EXT-1:0] ext_irq_req,
  output var logic [ICC_NUM_EXT-1:0]  ext_irq_pin,
  output logic [ICC_NUM_EXT-1:0][7:0] req_count
);
  //--------------------------------------------------------------
  // Pins
  //--------------------------------------------------------------
  // Level lands 1.3 ns after the bench edge, never on a clock edge
  initial ext_irq_pin = '0;
  always @(pin_target) ext_irq_pin <= #1.3 pin_target;

  // Count each cycle a request is high, per input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_count <= '0;
    end else begin
      for (int i = 0; i < ICC_NUM_EXT; i++) begin
        if (ext_irq_req[i]) begin
          req_count[i] <= req_count[i] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/interrupt_control_config_tb.sv ***
// Bench for icc_top: AHB-Lite register access, proximity gate, edges.
// Assumes zero-wait slave; requests counted by the core model.
`timescale 1ns/1ps
`default_nettype none
module interrupt_control_config_tb
  import icc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, irq_valid;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, irq_prio;
  logic        hreadyout, hresp, prox_start, multi_vec, shadow;
  logic [4:0]  pins, pin_target, req;
  logic [4:0][7:0] cnt;
  int          bad_count, total_checks;
  int          exp_cnt [5];

  icc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_irq_pin(pins), .ext_irq_req(req),
    .irq_valid(irq_valid), .irq_prio(irq_prio),
    .prox_timer_start(prox_start), .multi_vector_enable(multi_vec),
    .single_vector_shadow_select(shadow));
  icc_core_model PEER (.hclk(hclk), .hresetn(hresetn),
    .pin_target(pin_target), .ext_irq_req(req), .ext_irq_pin(pins),
    .req_count(cnt));

  //--------------------------------------------------------------
  // Shared tasks
  //--------------------------------------------------------------
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single transfer: hold address until hready, then data phase
  // Waits are ended only by the watchdog
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1; htrans <= ICC_HTRANS_NONSEQ; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp", {31'h0, hresp}, {31'h0, ICC_HRESP_OKAY});
  endtask

  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  //--------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------
  task automatic t_reg();
    bus(0, 32'h0, 0); check("reset", q, 32'h0);
    bus(1, 32'h0, 32'hffff_ffff); @(posedge hclk);
    check("multi_vec", {31'h0, multi_vec}, 32'h1);
    check("shadow", {31'h0, shadow}, 32'h1);
    bus(0, 32'h0, 0); check("ones", q, 32'h0001_171f);
    bus(1, 32'h8, 32'hffff_ffff); bus(0, 32'h8, 0);
    check("unmapped", q, 32'h0);
    bus(1, 32'h0, 32'h0001_0000); @(posedge hclk);
    check("multi_vec0", {31'h0, multi_vec}, 32'h0);
    check("shadow1", {31'h0, shadow}, 32'h1);
    bus(1, 32'h0, 32'h0000_1000); @(posedge hclk);
    check("multi_vec1", {31'h0, multi_vec}, 32'h1);
    check("shadow0", {31'h0, shadow}, 32'h0);
  endtask

  task automatic t_prox();
    logic e;
    for (int t = 0; t < 8; t++) begin
      bus(1, 32'h0, 32'(t) << 8);
      bus(0, 32'h0, 0); check("thresh", q, 32'(t) << 8);
      for (int p = 0; p < 8; p++) begin
        irq_valid <= 1'b1; irq_prio <= 3'(p); @(posedge hclk);
        e = (t == 1) ? (p == 1) : (t != 0 && p <= t);
        check("prox", {31'h0, prox_start}, {31'h0, e});
      end
      irq_valid <= 1'b0; @(posedge hclk);
      check("prox_idle", {31'h0, prox_start}, 32'h0);
    end
  endtask

  // Move all pins, then compare per-input request counts
  task automatic pin_step(logic [4:0] pol, logic [4:0] v);
    for (int i = 0; i < 5; i++)
      if (v[i] != pin_target[i] && v[i] == pol[i]) exp_cnt[i]++;
    pin_target <= v; repeat (8) @(posedge hclk);
    for (int i = 0; i < 5; i++)
      check("req_count", {24'h0, cnt[i]}, 32'(exp_cnt[i]));
    bus(0, 32'h4, 0); check("status", q, {27'h0, v});
  endtask

  task automatic t_edge();
    bus(1, 32'h0, 32'h15); pin_step(5'h15, 5'h1f); pin_step(5'h15, 5'h00);
    bus(1, 32'h0, 32'h0a); pin_step(5'h0a, 5'h1f); pin_step(5'h0a, 5'h00);
    pin_step(5'h0a, 5'h1f); pin_step(5'h0a, 5'h1f);
  endtask

  //--------------------------------------------------------------
  // Clock, reset, run and watchdog
  //--------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #40000; bad_count++; end_sim();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = ICC_HSIZE_WORD; hwdata = '0; hready = 1'b1; irq_valid = 1'b0;
    irq_prio = 3'h0; pin_target = 5'h00; bad_count = 0; total_checks = 0;
    exp_cnt = '{default: 0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    check("rst_multi_vec", {31'h0, multi_vec}, 32'h0);
    t_reg(); t_prox(); t_edge();
    end_sim();
  end
endmodule
`default_nettype wire
